// ---- pkg/shs_pkg.sv ----
// Purpose: Shared constants and types of the servo homing sequencer.
// Assumes: One 10 MHz core clock, AXI4-Lite register access.
// Notes:   Method codes are the signed method numbers held in 8 bits.
`default_nettype none
package shs_pkg;
   // ************************************************************
   // Register map and fields
   // ************************************************************
   localparam int          AXI_AW        = 8;
   localparam logic [7:0]  OFF_CTRL      = 8'h00;
   localparam logic [7:0]  OFF_CFG       = 8'h04;
   localparam logic [7:0]  OFF_TRQ       = 8'h08;
   localparam logic [7:0]  OFF_BLK       = 8'h0C;
   localparam logic [7:0]  OFF_HOME      = 8'h10;
   localparam logic [7:0]  OFF_STAT      = 8'h14;
   localparam int          CTRL_START    = 0;
   localparam int          CTRL_ABORT    = 1;
   localparam int          CTRL_METH_LSB = 8;
   localparam int          CFG_REF_FN    = 8;
   localparam int          IN_PLIM       = 0;
   localparam int          IN_NLIM       = 1;
   localparam int          IN_REF        = 2;
   localparam int          IN_IDX        = 3;
   localparam logic [31:0] CTRL_RST      = 32'h0000_0000;
   localparam logic [31:0] CFG_RST       = 32'h0000_0000;
   localparam logic [31:0] TRQ_RST       = 32'h0000_0100;
   localparam logic [31:0] BLK_RST       = 32'h0000_0064;
   localparam logic [31:0] HOME_RST      = 32'h0000_0000;
   localparam logic [1:0]  RESP_OK       = 2'h0;
   localparam logic [1:0]  RESP_SLVERR   = 2'h2;
   // ************************************************************
   // Timing
   // ************************************************************
   localparam int CLK_NS       = 100;
   localparam int TICK_NS      = 1_000_000;
   localparam int TICK_CYC_DEF = TICK_NS / CLK_NS;
   // ************************************************************
   // Method codes
   // ************************************************************
   localparam logic [7:0] M_10 = 8'h0A, M_11 = 8'h0B, M_14 = 8'h0E;
   localparam logic [7:0] M_17 = 8'h11, M_20 = 8'h14, M_21 = 8'h15;
   localparam logic [7:0] M_22 = 8'h16, M_23 = 8'h17, M_30 = 8'h1E;
   localparam logic [7:0] M_33 = 8'h21, M_34 = 8'h22, M_35 = 8'h23;
   localparam logic [7:0] M_N1 = 8'hFF, M_N2 = 8'hFE;
   localparam logic [7:0] M_N3 = 8'hFD, M_N4 = 8'hFC;
   localparam logic [2:0] STEP_LIM = 3'h3;
   // ************************************************************
   // Types
   // ************************************************************
   typedef enum logic [2:0] {
      EV_NONE, EV_REF_RISE, EV_REF_FALL, EV_IDX, EV_NLIM_RISE, EV_NLIM_FALL, EV_TORQUE
   } shs_ev_t;
   typedef enum logic [3:0] {
      ST_IDLE = 4'h1, ST_MOVE = 4'h2, ST_DONE = 4'h4, ST_FAULT = 4'h8
   } shs_state_t;
   typedef struct packed {
      logic dir; logic fast; logic move; shs_ev_t ev; logic last;
   } shs_step_t;
   typedef struct packed {logic run; logic dir; logic fast;} shs_motion_t;
   typedef struct packed {
      logic awvalid; logic [AXI_AW-1:0] awaddr; logic wvalid; logic [31:0] wdata;
      logic [3:0] wstrb; logic bready; logic arvalid; logic [AXI_AW-1:0] araddr;
      logic rready;
   } shs_axi_req_t;
   typedef struct packed {
      logic awready; logic wready; logic bvalid; logic [1:0] bresp;
      logic arready; logic rvalid; logic [31:0] rdata; logic [1:0] rresp;
   } shs_axi_rsp_t;
endpackage
`default_nettype wire

// ---- logic/shs_homing.sv ----
// Purpose: Homing sequencer for one servo axis, AXI4-Lite controlled.
// Assumes: Switch pins asynchronous, torque magnitude on the core clock.
// Notes:   Motion is a run/direction/speed command; zero run means stop.
// Function
// - Method 10, reference low: fast plus, slow at ref rise, past fall, stop at index.
// - Method 10, reference high: slow plus, stop at index after ref fall.
// - Method 10 positive limit: fast minus to ref rise, stop, slow plus to index.
// - Methods 11 to 14 mirror method 10 with negative limit and direction.
// - Methods 17-20, 23-30: fast minus to limit, slow back, home at limit fall.
// - Method 21, reference high: slow plus, stop at ref fall.
// - Method 21, reference low: fast minus to ref rise, slow plus to ref fall.
// - Method 22, reference high: fast plus to ref fall, slow back to ref rise.
// - Method 22, reference low: slow minus, stop at ref rise.
// - Method 34 slow plus to index; method 33 slow minus to index.
// - Method 35: no motion, present position becomes home.
// - Method -4: plus until torque blocked, reverse, home at first index.
// - Method -3: minus until torque blocked, reverse, home at first index.
// - Method -2: plus until torque blocked, then home at present position.
// - Method -1: minus until torque blocked, then home at present position.
// - Start direction follows sampled input level after polarity inversion.
//
// Our own choices: the address map and register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
module shs_homing
   import shs_pkg::*;
#(
   parameter int TICK_CYC = TICK_CYC_DEF,
   parameter int TRQ_W    = 16
) (
   input  wire logic         core_clk_i,
   input  wire logic         reset_n_i,
   input  wire shs_axi_req_t axi_req_i,
   output var  shs_axi_rsp_t axi_rsp_o,
   input  wire logic [3:0]   sw_pins_i,
   input  wire logic [TRQ_W-1:0] torque_i,
   output var  shs_motion_t  motion_o,
   output logic              home_load_o,
   output logic [31:0]       home_pos_o,
   output logic              done_o,
   output logic              fault_o
);
   import shs_pkg::*;

   if (TICK_CYC < 1 || TRQ_W < 1 || TRQ_W > 32) begin : g_bad_param
      $error("shs_homing: TICK_CYC or TRQ_W out of range");
   end

   // ************************************************************
   // Register bus
   // ************************************************************
   shs_axi_rsp_t rsp_q;
   logic [31:0]  ctrl_q, cfg_q, trq_q, blk_q, home_q;
   logic         start_q, abort_q;
   // The read mux needs sequencer state, so it is declared here and driven further down.
   logic         rd_map;
   logic [31:0]  rd_data;

   function automatic logic [31:0] wmerge(input logic [31:0] o, input logic [31:0] n,
                                          input logic [3:0] s);
      logic [31:0] r;
      r = o;
      for (int b = 0; b < 4; b++) begin
         if (s[b]) r[b*8 +: 8] = n[b*8 +: 8];
      end
      return r;
   endfunction

   wire logic       wr_go   = axi_req_i.awvalid && axi_req_i.wvalid && !rsp_q.awready
                              && !rsp_q.bvalid;
   wire logic       rd_go   = axi_req_i.arvalid && !rsp_q.arready && !rsp_q.rvalid;
   wire logic       wr_now  = rsp_q.awready;
   wire logic [7:0] wa      = axi_req_i.awaddr;
   wire logic [7:0] ra      = axi_req_i.araddr;
   wire logic       w_ctrl  = wr_now && wa == OFF_CTRL;
   wire logic       w_cfg   = wr_now && wa == OFF_CFG;
   wire logic       w_trq   = wr_now && wa == OFF_TRQ;
   wire logic       w_blk   = wr_now && wa == OFF_BLK;
   wire logic       w_home  = wr_now && wa == OFF_HOME;
   wire logic       w_map   = w_ctrl || w_cfg || w_trq || w_blk || w_home || wa == OFF_STAT;
   wire logic [31:0] w_ctl_v = wmerge(ctrl_q, axi_req_i.wdata, axi_req_i.wstrb);

   always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         rsp_q <= '0;
      end else begin
         rsp_q.awready <= wr_go;
         rsp_q.wready  <= wr_go;
         rsp_q.arready <= rd_go;
         if (wr_now) begin
            rsp_q.bvalid <= 1'b1;
            rsp_q.bresp  <= w_map ? RESP_OK : RESP_SLVERR;
         end else if (axi_req_i.bready) begin
            rsp_q.bvalid <= 1'b0;
         end
         if (rsp_q.arready) begin
            rsp_q.rvalid <= 1'b1;
            rsp_q.rdata  <= rd_data;
            rsp_q.rresp  <= rd_map ? RESP_OK : RESP_SLVERR;
         end else if (axi_req_i.rready) begin
            rsp_q.rvalid <= 1'b0;
         end
      end
   end
   assign axi_rsp_o = rsp_q;

   // Start and abort are write-one pulses; bits 31:2, method field included, are stored and bits 1:0 read as zero.
   always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         ctrl_q  <= CTRL_RST;
         cfg_q   <= CFG_RST;
         trq_q   <= TRQ_RST;
         blk_q   <= BLK_RST;
         home_q  <= HOME_RST;
         start_q <= 1'b0;
         abort_q <= 1'b0;
      end else begin
         start_q <= w_ctrl && w_ctl_v[CTRL_START];
         abort_q <= w_ctrl && w_ctl_v[CTRL_ABORT];
         if (w_ctrl) ctrl_q <= {w_ctl_v[31:2], 2'b00};
         if (w_cfg)  cfg_q  <= wmerge(cfg_q, axi_req_i.wdata, axi_req_i.wstrb);
         if (w_trq)  trq_q  <= wmerge(trq_q, axi_req_i.wdata, axi_req_i.wstrb);
         if (w_blk)  blk_q  <= wmerge(blk_q, axi_req_i.wdata, axi_req_i.wstrb);
         if (w_home) home_q <= wmerge(home_q, axi_req_i.wdata, axi_req_i.wstrb);
      end
   end

   // ************************************************************
   // Switch inputs
   // ************************************************************
   logic [3:0] s1_q, s2_q, s3_q, lvl_q, prv_q;
   wire logic [3:0] agree = ~(s2_q ^ s3_q);
   wire logic [3:0] lvl_d = (agree & (s3_q ^ cfg_q[3:0])) | (~agree & lvl_q);
   wire logic [3:0] rise  = lvl_q & ~prv_q;
   wire logic [3:0] fall  = ~lvl_q & prv_q;

   always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         {s1_q, s2_q, s3_q, lvl_q, prv_q} <= '0;
      end else begin
         s1_q  <= sw_pins_i;
         s2_q  <= s1_q;
         s3_q  <= s2_q;
         lvl_q <= lvl_d;
         prv_q <= lvl_q;
      end
   end

   // ************************************************************
   // Method decode and step plan
   // ************************************************************
   shs_state_t st_q;
   logic [2:0] step_q;
   logic       init_q;
   shs_step_t  cur;
   wire logic [7:0] meth  = ctrl_q[CTRL_METH_LSB +: 8];
   wire logic m_10x = meth >= M_10 && meth <= M_14;
   wire logic m_nl  = (meth >= M_17 && meth <= M_20) || (meth >= M_23 && meth <= M_30);
   wire logic m_21  = meth == M_21;
   wire logic m_22  = meth == M_22;
   wire logic m_34x = meth == M_33 || meth == M_34;
   wire logic m_tr2 = meth == M_N4 || meth == M_N3;
   wire logic m_tr1 = meth == M_N2 || meth == M_N1;
   wire logic mirror = (meth >= M_11 && meth <= M_14) || meth == M_N3 || meth == M_N1
                       || meth == M_33;
   wire logic ref_m  = m_10x || m_21 || m_22;
   wire logic known  = ref_m || m_nl || m_34x || m_tr2 || m_tr1 || meth == M_35;
   wire logic [2:0] step0 = ((m_21 && lvl_q[IN_REF]) || (m_22 && !lvl_q[IN_REF])) ?
                            3'h1 : 3'h0;

   always_comb begin
      cur = '{1'b0, 1'b0, 1'b0, EV_NONE, 1'b1};
      if (m_10x && init_q) begin
         cur = (step_q == 3'h0) ? '{1'b1, 1'b0, 1'b1, EV_REF_FALL, 1'b0}
                                : '{1'b1, 1'b0, 1'b1, EV_IDX, 1'b1};
      end else if (m_10x) begin
         case (step_q)
            3'h0: cur = '{1'b1, 1'b1, 1'b1, EV_REF_RISE, 1'b0};
            3'h1: cur = '{1'b1, 1'b0, 1'b1, EV_REF_FALL, 1'b0};
            3'h3: cur = '{1'b0, 1'b1, 1'b1, EV_REF_RISE, 1'b0};
            3'h4: cur = '{1'b0, 1'b0, 1'b0, EV_NONE, 1'b0};
            default: cur = '{1'b1, 1'b0, 1'b1, EV_IDX, 1'b1};
         endcase
      end else if (m_nl) begin
         cur = (step_q == 3'h0) ? '{1'b0, 1'b1, 1'b1, EV_NLIM_RISE, 1'b0}
                                : '{1'b1, 1'b0, 1'b1, EV_NLIM_FALL, 1'b1};
      end else if (m_21) begin
         cur = (step_q == 3'h0) ? '{1'b0, 1'b1, 1'b1, EV_REF_RISE, 1'b0}
                                : '{1'b1, 1'b0, 1'b1, EV_REF_FALL, 1'b1};
      end else if (m_22) begin
         cur = (step_q == 3'h0) ? '{1'b1, 1'b1, 1'b1, EV_REF_FALL, 1'b0}
                                : '{1'b0, 1'b0, 1'b1, EV_REF_RISE, 1'b1};
      end else if (m_34x) begin
         cur = '{1'b1, 1'b0, 1'b1, EV_IDX, 1'b1};
      end else if (m_tr2) begin
         cur = (step_q == 3'h0) ? '{1'b1, 1'b0, 1'b1, EV_TORQUE, 1'b0}
                                : '{1'b0, 1'b0, 1'b1, EV_IDX, 1'b1};
      end else if (m_tr1) begin
         cur = '{1'b1, 1'b0, 1'b1, EV_TORQUE, 1'b1};
      end
      if (mirror) cur.dir = ~cur.dir;
   end

   // ************************************************************
   // End-stop torque detection
   // ************************************************************
   localparam int TW = $clog2(TICK_CYC + 1);
   logic [TW-1:0] tick_cnt_q;
   logic [15:0]   blk_cnt_q;
   wire logic tick  = tick_cnt_q == TW'(TICK_CYC - 1);
   wire logic above = torque_i >= trq_q[TRQ_W-1:0];
   wire logic tr_on = st_q == ST_MOVE && cur.ev == EV_TORQUE && above;
   wire logic trq_det = tr_on && blk_cnt_q >= blk_q[15:0];

   always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         tick_cnt_q <= '0;
         blk_cnt_q  <= '0;
      end else begin
         tick_cnt_q <= tick ? '0 : tick_cnt_q + 1'b1;
         if (!tr_on) blk_cnt_q <= '0;
         else if (tick && blk_cnt_q != 16'hFFFF) blk_cnt_q <= blk_cnt_q + 1'b1;
      end
   end

   // ************************************************************
   // Sequencer
   // ************************************************************
   logic ev_hit;
   always_comb begin
      case (cur.ev)
         EV_REF_RISE:  ev_hit = rise[IN_REF];
         EV_REF_FALL:  ev_hit = fall[IN_REF];
         EV_IDX:       ev_hit = rise[IN_IDX];
         EV_NLIM_RISE: ev_hit = rise[IN_NLIM];
         EV_NLIM_FALL: ev_hit = fall[IN_NLIM];
         EV_TORQUE:    ev_hit = trq_det;
         default:      ev_hit = 1'b1;
      endcase
   end
   // limit hit during the fast search
   wire logic lim_br  = st_q == ST_MOVE && m_10x && !init_q && step_q == 3'h0
                        && (mirror ? rise[IN_NLIM] : rise[IN_PLIM]);
   wire logic finish  = st_q == ST_MOVE && !lim_br && ev_hit && cur.last && !abort_q;
   wire logic cfg_bad = !known || (ref_m && !cfg_q[CFG_REF_FN]);

   always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         st_q   <= ST_IDLE;
         step_q <= '0;
         init_q <= 1'b0;
      end else if (abort_q) begin
         st_q <= ST_IDLE;
      end else begin
         case (st_q)
            ST_MOVE: begin
               if (lim_br) step_q <= STEP_LIM;
               else if (finish) st_q <= ST_DONE;
               else if (ev_hit) step_q <= step_q + 1'b1;
            end
            default: begin
               if (start_q) begin
                  st_q   <= cfg_bad ? ST_FAULT : ST_MOVE;
                  step_q <= step0;
                  init_q <= lvl_q[IN_REF];
               end
            end
         endcase
      end
   end

   always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         motion_o    <= '0;
         home_load_o <= 1'b0;
         home_pos_o  <= '0;
         done_o      <= 1'b0;
         fault_o     <= 1'b0;
      end else begin
         motion_o    <= (st_q == ST_MOVE && cur.move) ? '{1'b1, cur.dir, cur.fast} : '0;
         home_load_o <= finish;
         if (finish) home_pos_o <= home_q;
         done_o      <= finish || (done_o && !start_q);
         fault_o     <= (st_q == ST_FAULT) && !start_q;
      end
   end

   assign rd_map  = ra == OFF_CTRL || ra == OFF_CFG || ra == OFF_TRQ
                    || ra == OFF_BLK || ra == OFF_HOME || ra == OFF_STAT;
   wire logic [31:0] stat_v  = {16'h0000, init_q, fault_o, done_o, 2'b00, step_q,
                                4'h0, st_q};
   assign rd_data = ra == OFF_CTRL ? ctrl_q : ra == OFF_CFG ? cfg_q :
                    ra == OFF_TRQ ? trq_q : ra == OFF_BLK ? blk_q :
                    ra == OFF_HOME ? home_q : ra == OFF_STAT ? stat_v : '0;

   // ************************************************************
   // Checks
   // ************************************************************
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (!reset_n_i);
   wire logic go10 = st_q != ST_MOVE && start_q && !cfg_bad && meth == M_10;

   stop_on_home_a: assert property (home_load_o |-> ##1 !motion_o.run)
      else $error("motion not stopped after home load");
   home_val_a: assert property (home_load_o |-> done_o && home_pos_o == home_q)
      else $error("home value or done flag wrong");
   ref_slow_a: assert property (st_q == ST_MOVE && meth == M_10 && !init_q && step_q == 3'h0
      && rise[IN_REF] && !lim_br |=> step_q == 3'h1 ##1 motion_o == 3'b110)
      else $error("no slow positive after reference rise");
   ref_high_a: assert property (go10 && lvl_q[IN_REF] |-> ##2 motion_o == 3'b110)
      else $error("reference high start not slow positive");
   lim_rev_a: assert property (lim_br && !mirror |=> step_q == STEP_LIM
      ##1 motion_o == 3'b101)
      else $error("no fast reverse after limit");
   nlim_back_a: assert property (st_q == ST_MOVE && m_nl && step_q == 3'h0
      && rise[IN_NLIM] |=> ##1 motion_o == 3'b110)
      else $error("no slow return after negative limit");
   set_here_a: assert property (st_q != ST_MOVE && start_q && meth == M_35
      |-> ##2 home_load_o && !motion_o.run)
      else $error("method 35 did not home in place");
   trq_det_a: assert property (trq_det && !abort_q |=> step_q != $past(step_q)
      || st_q == ST_DONE)
      else $error("blocked torque did not advance");

   home_seen_c: cover property (home_load_o);
   lim_path_c: cover property (lim_br ##[1:1000] home_load_o);
   trq_path_c: cover property (trq_det ##[1:1000] home_load_o);
endmodule  // shs_homing
`default_nettype wire

// ---- test/shs_axis_model.sv ----
// Purpose: Axis model with limit, reference and index switches.
// Assumes: One move step per 16 clocks, 4 units fast, 1 unit slow.
// Notes:   Hard ends at +/-400 stall the axis and raise torque.
`timescale 1ns/1ps
`default_nettype none
module shs_axis_model (
   input  wire logic                 clk_i,
   input  wire logic                 rst_n_i,
   input  wire shs_pkg::shs_motion_t motion_i,
   input  wire logic                 set_i,
   input  wire logic [31:0]          set_pos_i,
   output logic [3:0]                pins_o,
   output logic                      blocked_o,
   output logic [31:0]               pos_o
);
   import shs_pkg::*;
   logic signed [31:0] pos_q;
   logic [3:0]         div_q;
   logic               at_end;
   // ******************************************************
   // Switch geometry
   // ******************************************************
   // The slow step period exceeds the stop latency, so the axis rests on the event.
   assign at_end    = (pos_q >= 400 && motion_i.dir) || (pos_q <= -400 && !motion_i.dir);
   assign blocked_o = motion_i.run && at_end;
   assign pins_o    = {pos_q % 64 == 0, pos_q >= 100 && pos_q <= 199,
                       pos_q <= -380, pos_q >= 380};
   assign pos_o     = pos_q;
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         pos_q <= 32'sh0000_0000;
         div_q <= 4'h0;
      end else if (set_i) begin
         pos_q <= set_pos_i;
         div_q <= 4'h0;
      end else begin
         div_q <= div_q + 4'h1;
         if (motion_i.run && div_q == 4'hF && !at_end) begin
            pos_q <= pos_q + (motion_i.dir ? 1 : -1) * (motion_i.fast ? 4 : 1);
         end
      end
   end
endmodule // shs_axis_model
`default_nettype wire

// ---- test/shs_homing_tb_top.sv ----
// Purpose: Self-checking bench of the servo homing sequencer.
// Assumes: Reference switch over 100..199, limit switches at +/-380.
// Notes:   Tick shortened to 4 clocks, blocking time 2 ticks.
`timescale 1ns/1ps
`default_nettype none
module shs_homing_tb_top;
   import shs_pkg::*;
   typedef struct {logic [31:0] pos; logic [31:0] home;} shs_note_t;
   logic         clk     = 1'b0;
   logic         rst_n   = 1'b0;
   shs_axi_req_t req     = '0;
   shs_axi_rsp_t rsp;
   shs_motion_t  mot;
   logic [3:0]   pins;
   logic [15:0]  trq     = 16'h0000;
   logic         hload, done, fault, blk;
   logic         set     = 1'b0;
   logic [31:0]  hpos, pos;
   logic [31:0]  set_pos = 32'h0000_0000;
   int           err_count = 0;
   int           compares  = 0;
   int           cyc       = 0;
   shs_note_t    notes[$];
   shs_note_t    nt;
   logic [7:0]   mt [20] = '{M_10, M_10, M_10, M_11, M_14, M_17, M_20, M_23, M_30, M_21,
                             M_21, M_22, M_22, M_33, M_34, M_35, M_N4, M_N3, M_N2, M_N1};
   int           st [20] = '{0, 150, 240, 300, 300, 0, 0, 0, 0, 150,
                             300, 150, 300, 10, 10, 77, 350, -350, 350, -350};
   int           ex [20] = '{256, 256, 256, 64, 64, -379, -379, -379, -379, 200,
                             200, 199, 199, 0, 64, 77, 384, -384, 400, -400};
   shs_homing #(.TICK_CYC(4), .TRQ_W(16)) dut (
      .core_clk_i(clk), .reset_n_i(rst_n), .axi_req_i(req), .axi_rsp_o(rsp),
      .sw_pins_i(pins), .torque_i(trq), .motion_o(mot), .home_load_o(hload),
      .home_pos_o(hpos), .done_o(done), .fault_o(fault));
   shs_axis_model m (
      .clk_i(clk), .rst_n_i(rst_n), .motion_i(mot), .set_i(set),
      .set_pos_i(set_pos), .pins_o(pins), .blocked_o(blk), .pos_o(pos));
   always #50 clk = ~clk;
   always @(posedge clk) begin
      trq <= blk ? TRQ_RST[15:0] + 16'($urandom % 16) : 16'($urandom % 256);
      cyc <= cyc + 1;
      if (cyc == 80000) begin
         err_count++;
         print_verdict();
      end
   end
   // ******************************************************
   // Tasks
   // ******************************************************
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         err_count++;
         $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic print_verdict();
      $display("compares %0d mismatches %0d", compares, err_count);
      if (err_count == 0 && compares > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      @(posedge clk);
      req <= '{awvalid: 1'b1, awaddr: a, wvalid: 1'b1, wdata: d, wstrb: 4'hF,
               bready: 1'b1, default: '0};
      do begin
         @(posedge clk);
         if (rsp.awready) req.awvalid <= 1'b0;
         if (rsp.wready) req.wvalid <= 1'b0;
      end while (rsp.bvalid !== 1'b1);
      req.bready <= 1'b0;
      chk("bresp", 32'(rsp.bresp), 32'(er));
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
      @(posedge clk);
      req <= '{arvalid: 1'b1, araddr: a, rready: 1'b1, default: '0};
      do begin
         @(posedge clk);
         if (rsp.arready) req.arvalid <= 1'b0;
      end while (rsp.rvalid !== 1'b1);
      req.rready <= 1'b0;
      chk("rresp", 32'(rsp.rresp), 32'(er));
      chk("rdata", rsp.rdata, exp);
   endtask
   task automatic setp(input int p);
      @(posedge clk);
      set <= 1'b1;
      set_pos <= 32'(p);
      @(posedge clk);
      set <= 1'b0;
   endtask
   task automatic strt(input logic [7:0] meth);
      wr(OFF_CTRL, {16'h0000, meth, 8'h01}, RESP_OK);
   endtask
   task automatic wait_end();
      int n;
      n = 0;
      repeat (4) @(posedge clk);
      while (done !== 1'b1 && fault !== 1'b1 && n < 6000) begin
         @(posedge clk);
         n++;
      end
   endtask
   task automatic run_m(input logic [7:0] meth, input int p, input int e);
      logic [31:0] h;
      h = $urandom;
      setp(p);
      wr(OFF_HOME, h, RESP_OK);
      notes.push_back('{32'(e), h});
      strt(meth);
      wait_end();
      chk("done", 32'(done), 32'h0000_0001);
      repeat (2) @(posedge clk);
      chk("run", 32'(mot.run), 32'h0000_0000);
   endtask
   always @(posedge clk) begin
      if (hload === 1'b1 && notes.size() > 0) begin
         nt = notes.pop_front();
         chk("home_pos", hpos, nt.home);
         chk("stop_pos", pos, nt.pos);
      end else if (hload === 1'b1) begin
         chk("extra_load", 32'h0000_0001, 32'h0000_0000);
      end
   end
   // ******************************************************
   // Sequence
   // ******************************************************
   initial begin
      void'($urandom(94));
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      rd(OFF_CTRL, CTRL_RST, RESP_OK);
      rd(OFF_CFG, CFG_RST, RESP_OK);
      rd(OFF_TRQ, TRQ_RST, RESP_OK);
      rd(OFF_BLK, BLK_RST, RESP_OK);
      rd(OFF_HOME, HOME_RST, RESP_OK);
      rd(OFF_STAT, 32'h0000_0001, RESP_OK);
      rd(8'h18, 32'h0000_0000, RESP_SLVERR);
      wr(8'h18, 32'h0000_0005, RESP_SLVERR);
      $display("test registers done");
      wr(OFF_BLK, 32'h0000_0002, RESP_OK);
      wr(OFF_CFG, 32'h0000_0100, RESP_OK);
      for (int i = 0; i < 20; i++) begin
         run_m(mt[i], st[i], ex[i]);
         $display("test method %0d done", i);
      end
      wr(OFF_CFG, 32'h0000_0104, RESP_OK);
      setp(0);
      strt(M_22);
      repeat (8) @(posedge clk);
      chk("dir_inv", 32'(mot), 32'h0000_0007);
      wr(OFF_CTRL, 32'h0000_0002, RESP_OK);
      repeat (4) @(posedge clk);
      chk("abort_run", 32'(mot.run), 32'h0000_0000);
      wr(OFF_CFG, 32'h0000_0100, RESP_OK);
      strt(M_22);
      repeat (8) @(posedge clk);
      chk("dir_plain", 32'(mot), 32'h0000_0004);
      wr(OFF_CTRL, 32'h0000_0002, RESP_OK);
      $display("test polarity done");
      strt(8'h01);
      wait_end();
      chk("bad_method", 32'(fault), 32'h0000_0001);
      wr(OFF_CFG, 32'h0000_0000, RESP_OK);
      strt(M_21);
      wait_end();
      chk("no_ref_fn", 32'(fault), 32'h0000_0001);
      chk("notes_left", 32'(notes.size()), 32'h0000_0000);
      $display("test faults done");
      print_verdict();
   end
endmodule // shs_homing_tb_top
`default_nettype wire
